//--- crcl_host_model.sv
// Purpose: host that loads reference and control data over the loader pins
// Assumes: pins change just after rising pclk edges
// Notes: after a strobe edge the data pins show the inverse of the last value
`timescale 1ns/1ps
module crcl_host_model (
    // system
    input wire logic pclk,
    // reference port
    output logic [7:0] ref_in_bus,
    output logic ref_load_strobe,
    output logic array_transfer_n,
    // control port
    output logic [7:0] ctrl_in_bus,
    output logic ctrl_load_strobe_n,
    output logic [2:0] ctrl_addr,
    output logic aux_out_enable_n
);
    initial begin
        ref_in_bus = 8'h00;
        ref_load_strobe = 1'b0;
        array_transfer_n = 1'b1;
        ctrl_in_bus = 8'h00;
        ctrl_load_strobe_n = 1'b1;
        ctrl_addr = 3'h7;
        aux_out_enable_n = 1'b1;
    end
    // data held well around the rising strobe edge
    task automatic ref_load(input logic [7:0] d);
        ref_in_bus <= d;
        repeat (5) @(posedge pclk);
        ref_load_strobe <= 1'b1;
        repeat (6) @(posedge pclk);
        ref_in_bus <= ~d;
        ref_load_strobe <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask
    // address and data stable until after strobe release
    task automatic ctrl_load(input logic [2:0] a, input logic [7:0] d);
        ctrl_addr <= a;
        ctrl_in_bus <= d;
        repeat (5) @(posedge pclk);
        ctrl_load_strobe_n <= 1'b0;
        repeat (5) @(posedge pclk);
        ctrl_load_strobe_n <= 1'b1;
        repeat (6) @(posedge pclk);
        ctrl_addr <= ~a;
        ctrl_in_bus <= ~d;
        repeat (5) @(posedge pclk);
    endtask
    task automatic xfer();
        array_transfer_n <= 1'b0;
        @(posedge pclk);
        array_transfer_n <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    task automatic set_oe(input logic v);
        aux_out_enable_n <= v;
        repeat (8) @(posedge pclk);
    endtask
endmodule

//--- crcl_loader.sv
// Purpose: reference and control loading port of a 256-tap correlator
// Assumes: host pins asynchronous; transfer enable and score on pclk
// Notes: apb gives status and tap readback
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "crcl_regs.svh"
module crcl_loader (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // host reference port
    input wire logic [7:0] ref_in_bus,
    input wire logic ref_load_strobe,
    input wire logic array_transfer_n,
    // host control port
    input wire logic [7:0] ctrl_in_bus,
    input wire logic ctrl_load_strobe_n,
    input wire logic [2:0] ctrl_addr,
    // auxiliary output
    input wire logic [8:0] second_score,
    input wire logic aux_out_enable_n,
    output logic [8:0] aux_out_bus,
    output logic aux_out_oe,
    // correlation array
    output logic [7:0][31:0] ref_array,
    output logic [7:0][31:0] mask_array,
    output crcl_pkg::crcl_cfg_type cfg,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    crcl_pkg::crcl_pins_type pins_raw;
    crcl_pkg::crcl_pins_type pins_q;
    logic ref_stb_prev;
    logic ctrl_stb_prev;
    logic ref_edge;
    logic ctrl_edge;
    logic [7:0][31:0] pre_ref;
    logic [7:0][31:0] pre_mask;
    logic [7:0] ref_tail;
    logic [7:0] mask_tail;
    logic [7:0] feed_ref;
    logic [7:0] feed_mask;
    logic [7:0] ref_out;
    logic [7:0] tap_sel;
    logic [15:0] ref_loads;
    logic [15:0] ctrl_loads;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic [31:0] next_prdata;

    // apb offset to register index, unmapped gives none
    function automatic logic [2:0] reg_index(input logic [11:0] a);
        unique case (a)
            `CRCL_OFF_STATUS: reg_index = 3'h0;
            `CRCL_OFF_TAPSEL: reg_index = 3'h1;
            `CRCL_OFF_TAPRD: reg_index = 3'h2;
            `CRCL_OFF_COUNT: reg_index = 3'h3;
            default: reg_index = `CRCL_IDX_NONE;
        endcase
    endfunction

    // host pins other than transfer enable cross into pclk together
    always_comb begin
        pins_raw.ref_data = ref_in_bus;
        pins_raw.ref_stb = ref_load_strobe;
        pins_raw.ctrl_data = ctrl_in_bus;
        pins_raw.ctrl_stb_n = ctrl_load_strobe_n;
        pins_raw.addr = ctrl_addr;
        pins_raw.oe_n = aux_out_enable_n;
    end

    crcl_sync3 #(
        .W(`CRCL_PIN_W),
        .IDLE(`CRCL_PIN_IDLE)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(pins_raw),
        .q(pins_q)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_stb_prev <= 1'b0;
            ctrl_stb_prev <= 1'b1;
        end else begin
            ref_stb_prev <= pins_q.ref_stb;
            ctrl_stb_prev <= pins_q.ctrl_stb_n;
        end
    end

    // [RQ12] rising edges of both strobes
    assign ref_edge = pins_q.ref_stb & ~ref_stb_prev;
    assign ctrl_edge = pins_q.ctrl_stb_n & ~ctrl_stb_prev;

    always_comb begin
        for (int s = 0; s < 8; s++) begin
            ref_tail[s] = pre_ref[s][31];
            mask_tail[s] = pre_mask[s][31];
            ref_out[7-s] = ref_array[s][31];
        end
    end

    // [RQ4] stage order per window shape
    crcl_tap_feed u_feed_ref (
        .rows_log(cfg.rows_log),
        .din(pins_q.ref_data),
        .tail(ref_tail),
        .feed(feed_ref)
    );

    // [RQ9] mask uses same ordering
    crcl_tap_feed u_feed_mask (
        .rows_log(cfg.rows_log),
        .din(pins_q.ctrl_data),
        .tail(mask_tail),
        .feed(feed_mask)
    );

    // [RQ1] reference bus only feeds preload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ref <= '0;
        end else if (ref_edge) begin
            for (int s = 0; s < 8; s++) begin
                pre_ref[s] <= {pre_ref[s][30:0], feed_ref[s]};
            end
        end
    end

    // [RQ10] mask destination picked by address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_mask <= '0;
        end else if (ctrl_edge && pins_q.addr == `CRCL_ADDR_MASK) begin
            for (int s = 0; s < 8; s++) begin
                pre_mask[s] <= {pre_mask[s][30:0], feed_mask[s]};
            end
        end
    end

    // [RQ11] address selects the function
    // [RQ8] configuration from control bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `CRCL_CFG_RST;
        end else if (ctrl_edge && pins_q.addr == `CRCL_ADDR_CFG) begin
            cfg.rows_log <= pins_q.ctrl_data[`CRCL_CFG_ROWS_MSB:`CRCL_CFG_ROWS_LSB];
            cfg.two_corr <= pins_q.ctrl_data[`CRCL_CFG_TWO_BIT];
        end
    end

    // [RQ7] array loads from preload on transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_array <= '0;
            mask_array <= '0;
        end else if (!array_transfer_n) begin
            ref_array <= pre_ref;
            mask_array <= pre_mask;
        end
    end

    // [RQ13] score or reference out on aux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_out_bus <= '0;
        end else if (cfg.two_corr) begin
            aux_out_bus <= second_score;
        end else begin
            aux_out_bus <= {1'b0, ref_out};
        end
    end

    // [RQ15] enable gates drivers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_out_oe <= 1'b0;
        end else begin
            aux_out_oe <= ~pins_q.oe_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_loads <= '0;
            ctrl_loads <= '0;
        end else begin
            if (ref_edge) begin
                ref_loads <= ref_loads + 16'h0001;
            end
            if (ctrl_edge) begin
                ctrl_loads <= ctrl_loads + 16'h0001;
            end
        end
    end

    // apb: no wait state, answer prepared in setup
    assign wr_idx = reg_index(paddr);
    assign rd_idx = reg_index(paddr);

    always_comb begin
        next_prdata = '0;
        unique case (rd_idx)
            3'h0: next_prdata = {28'h0, pins_q.oe_n, cfg};
            3'h1: next_prdata = {24'h0, tap_sel};
            3'h2: next_prdata = {28'h0, pre_mask[tap_sel[7:5]][tap_sel[4:0]],
                pre_ref[tap_sel[7:5]][tap_sel[4:0]], mask_array[tap_sel[7:5]][tap_sel[4:0]],
                ref_array[tap_sel[7:5]][tap_sel[4:0]]};
            3'h3: next_prdata = {ctrl_loads, ref_loads};
            default: next_prdata = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0 : next_prdata;
            pslverr <= (rd_idx == `CRCL_IDX_NONE);
        end else begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_sel <= `CRCL_TAPSEL_RST;
        end else if (psel && penable && pready && pwrite && wr_idx == 3'h1) begin
            tap_sel <= pwdata[7:0];
        end
    end

    // checks
    sequence s_ref_load;
        pins_q.oe_n && ref_edge ##1 1'b1;
    endsequence

    sequence s_two_mode;
        cfg.two_corr [*2];
    endsequence

    // [RQ2] capture on strobe edge
    a_ref_capture: assert property (ref_edge |=> pre_ref[0][0] == $past(feed_ref[0]) // [RQ2]
        && pre_ref[0][31:1] == $past(pre_ref[0][30:0]))
        else $error("reference preload missed the strobe edge");

    // [RQ3] serial chain in one line
    a_serial_chain: assert property (ref_edge && cfg.rows_log == `CRCL_ROWS_1 |=> // [RQ3]
        pre_ref[0][0] == $past(pins_q.ref_data[7]) && pre_ref[1][0] == $past(pre_ref[0][31]))
        else $error("serial reference chain broken");

    // [RQ4] parallel eight rows
    a_par_rows: assert property (ref_edge && cfg.rows_log == `CRCL_ROWS_8 |=> // [RQ4]
        pre_ref[0][0] == $past(pins_q.ref_data[7]) && pre_ref[7][0] == $past(pins_q.ref_data[0]))
        else $error("parallel reference order wrong");

    // [RQ17] two rows of four stages
    a_two_rows: assert property (ref_edge && cfg.rows_log == `CRCL_ROWS_2 |=> // [RQ17]
        pre_ref[4][0] == $past(pins_q.ref_data[6]) && pre_ref[5][0] == $past(pre_ref[4][31]))
        else $error("two row reference order wrong");

    // [RQ17] four rows of two stages
    a_four_rows: assert property (ref_edge && cfg.rows_log == `CRCL_ROWS_4 |=> // [RQ17]
        pre_ref[6][0] == $past(pins_q.ref_data[4]) && pre_ref[3][0] == $past(pre_ref[2][31]))
        else $error("four row reference order wrong");

    // [RQ5] preload moves only on loads
    a_ref_kept: assert property (!ref_edge |=> $stable(pre_ref)) // [RQ5]
        else $error("reference preload changed without a load");

    // [RQ6] array held without transfer
    a_array_held: assert property (array_transfer_n |=> $stable(ref_array) && $stable(mask_array)) // [RQ6]
        else $error("array changed without transfer");

    // [RQ7] copy on transfer
    a_xfer_copy: assert property (!array_transfer_n |=> ref_array == $past(pre_ref) // [RQ7]
        && mask_array == $past(pre_mask))
        else $error("transfer did not copy preload");

    // [RQ9] mask follows ordering
    a_mask_load: assert property (ctrl_edge && pins_q.addr == `CRCL_ADDR_MASK |=> // [RQ9]
        pre_mask[0][0] == $past(feed_mask[0]) && $stable(cfg))
        else $error("mask load wrong");

    // [RQ9] eighth mask stage takes bit 0
    a_mask_rows: assert property (ctrl_edge && pins_q.addr == `CRCL_ADDR_MASK // [RQ9]
        && cfg.rows_log == `CRCL_ROWS_8 |=> pre_mask[7][0] == $past(pins_q.ctrl_data[0]))
        else $error("parallel mask order wrong");

    // [RQ10] mask moves only on its address
    a_mask_kept: assert property (!(ctrl_edge && pins_q.addr == `CRCL_ADDR_MASK) |=> // [RQ10]
        $stable(pre_mask))
        else $error("mask preload changed without a mask load");

    // [RQ12] configuration sampled at edge
    a_cfg_write: assert property (ctrl_edge && pins_q.addr == `CRCL_ADDR_CFG |=> // [RQ12]
        cfg == $past(pins_q.ctrl_data[2:0]))
        else $error("configuration not written");

    // [RQ11] configuration moves only on its address
    a_cfg_kept: assert property (!(ctrl_edge && pins_q.addr == `CRCL_ADDR_CFG) |=> // [RQ11]
        $stable(cfg))
        else $error("configuration changed without a write");

    // [RQ16] unused codes have no effect
    a_unused_addr: assert property (ctrl_edge && pins_q.addr > `CRCL_ADDR_CFG |=> // [RQ16]
        $stable(cfg) && $stable(pre_mask))
        else $error("unused address changed state");

    // [RQ13] second score on aux
    a_aux_score: assert property (s_two_mode |-> aux_out_bus == $past(second_score)) // [RQ13]
        else $error("aux does not carry second score");

    // [RQ14] reference out in single mode
    a_aux_ref: assert property (!cfg.two_corr |=> aux_out_bus[7:0] == $past(ref_out)) // [RQ14]
        else $error("aux does not carry reference data");

    // [RQ15] disabled drivers, loading goes on
    a_aux_oe: assert property (s_ref_load |-> !aux_out_oe && pre_ref[0][0] == $past(feed_ref[0])) // [RQ15]
        else $error("aux drivers not disabled or loading stalled");

    // [RQ15] enable pin low drives aux
    a_oe_on: assert property (!pins_q.oe_n |=> aux_out_oe) // [RQ15]
        else $error("aux drivers not enabled");

    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    // unmapped offsets answer with an error and no data
    a_apb_error: assert property (psel && !penable && rd_idx == `CRCL_IDX_NONE |=> pslverr && prdata == '0)
        else $error("unmapped offset not refused");
endmodule

//--- crcl_pkg.sv
// Purpose: shared types of the reference and control loader
// Assumes: nothing
// Notes: field order of crcl_pins_type matches the idle constant
package crcl_pkg;

    typedef struct packed {
        logic two_corr;
        logic [1:0] rows_log;
    } crcl_cfg_type;

    typedef struct packed {
        logic [7:0] ref_data;
        logic ref_stb;
        logic [7:0] ctrl_data;
        logic ctrl_stb_n;
        logic [2:0] addr;
        logic oe_n;
    } crcl_pins_type;

endpackage

//--- crcl_regs.svh
// Purpose: named constants of the correlator reference and control loader
// Assumes: included by its bare name
// Notes: the list below explains how the loader behaves
// How it works
// [RQ1] 8-bit reference bus, bit 0 least significant, only feeds reference preload
// [RQ2] each rising reference strobe edge captures the reference bus into preload
// [RQ3] single 256-tap line: one bit per strobe on bit 7, shifted serially
// [RQ4] eight rows of 32: bit 7 feeds first stage, bit 0 the eighth
// [RQ5] changing window configuration never alters stored reference bits
// [RQ6] preload reaches the array only by transfer; loading leaves array intact
// [RQ7] array copies preload on each clock edge with transfer enable low
// [RQ8] 8-bit control bus carries mask bits and configuration contents
// [RQ9] mask bits follow the same stage ordering as reference loading
// [RQ10] active-low control strobe captures control bus, address picks destination
// [RQ11] 3-bit address, bit 0 least significant, selects the load function
// [RQ12] address and control data sampled at the control strobe rising edge
// [RQ13] two correlators: auxiliary output carries the second correlator score
// [RQ14] one correlator: auxiliary bits 0 to 7 carry reference data out
// [RQ15] high auxiliary enable disables drivers only, processing continues
// [RQ16] fixed address map: mask, configuration; other codes do nothing
// [RQ17] intermediate windows spread bits by rows, highest input bits first
`ifndef CRCL_REGS_SVH
`define CRCL_REGS_SVH

// control port address map
`define CRCL_ADDR_MASK 3'h0
`define CRCL_ADDR_CFG 3'h1

// configuration register layout
`define CRCL_CFG_ROWS_LSB 0
`define CRCL_CFG_ROWS_MSB 1
`define CRCL_CFG_TWO_BIT 2
`define CRCL_CFG_RST 3'h0
`define CRCL_ROWS_8 2'h3
`define CRCL_ROWS_1 2'h0
`define CRCL_ROWS_2 2'h1
`define CRCL_ROWS_4 2'h2

// synchronised pin vector: width and idle level
`define CRCL_PIN_W 22
`define CRCL_PIN_IDLE 22'h000011

// apb register byte offsets
`define CRCL_OFF_STATUS 12'h000
`define CRCL_OFF_TAPSEL 12'h004
`define CRCL_OFF_TAPRD 12'h008
`define CRCL_OFF_COUNT 12'h00C
`define CRCL_IDX_NONE 3'h4
`define CRCL_TAPSEL_RST 8'h00

`endif

//--- crcl_sync3.sv
// Purpose: three-stage synchroniser for the host pins
// Assumes: inputs asynchronous to clk
// Notes: output follows only when stages two and three agree
`timescale 1ns/1ps
module crcl_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, filtered level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= IDLE;
            s2 <= IDLE;
            s3 <= IDLE;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= IDLE;
        end else if (s2 == s3) begin
            q <= s3;
        end
    end
endmodule

//--- crcl_tap_feed.sv
// Purpose: picks the shift-in bit of each of the eight stages
// Assumes: rows_log 0..3 gives 1, 2, 4 or 8 rows
// Notes: a row's first stage takes an input bit, later stages chain
`timescale 1ns/1ps
module crcl_tap_feed (
    // window shape
    input wire logic [1:0] rows_log,
    // new bits and stage tails
    input wire logic [7:0] din,
    input wire logic [7:0] tail,
    // stage shift-in bits
    output logic [7:0] feed
);
    genvar s;
    generate
        for (s = 0; s < 8; s++) begin : g_stage
            logic [2:0] sh;
            logic [2:0] row;
            logic first;
            always_comb begin
                sh = 3'd3 - {1'b0, rows_log};
                row = 3'(s) >> sh;
                first = ((3'(s) & ((3'd1 << sh) - 3'd1)) == 3'd0);
            end
            // [RQ17] rows take msb first
            if (s == 0) begin : g_head
                assign feed[s] = din[3'd7 - row];
            end else begin : g_body
                assign feed[s] = first ? din[3'd7 - row] : tail[s-1];
            end
        end
    endgenerate
endmodule

//--- tb_correlator_reference_control_loader.sv
// Purpose: self-checking bench of the reference and control loader
// Assumes: host pins come from the host model, apb from this bench
// Notes: expected arrays are rebuilt here from the stage ordering
`timescale 1ns/1ps
`include "crcl_regs.svh"
module tb_correlator_reference_control_loader;
    typedef struct packed {
        logic [2:0] cfg;
        logic [7:0] rd;
        logic [7:0] md;
        logic [5:0] n;
        logic [8:0] sc;
    } crcl_row_type;
    logic pclk, presetn, ref_load_strobe, array_transfer_n, ctrl_load_strobe_n, aux_out_enable_n;
    logic [7:0] ref_in_bus, ctrl_in_bus;
    logic [2:0] ctrl_addr, e_cfg;
    logic [8:0] second_score, aux_out_bus;
    logic aux_out_oe, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0][31:0] ref_array, mask_array, e_pre_ref, e_pre_mask, e_ref, e_mask;
    crcl_pkg::crcl_cfg_type cfg;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int miscompares, cmp_count, nref, nctrl;
    crcl_row_type r;
    crcl_row_type rows [0:5] = '{{3'h0, 8'hA5, 8'h3C, 6'd3, 9'h000}, {3'h1, 8'h96, 8'hF0, 6'd2, 9'h000},
        {3'h2, 8'h5A, 8'h0F, 6'd2, 9'h000}, {3'h3, 8'hC3, 8'h81, 6'd32, 9'h000},
        {3'h7, 8'h00, 8'hFF, 6'd1, 9'h1A5}, {3'h4, 8'hFF, 8'h55, 6'd1, 9'h0FF}};

    crcl_loader uut (.pclk, .presetn, .ref_in_bus, .ref_load_strobe, .array_transfer_n, .ctrl_in_bus,
        .ctrl_load_strobe_n, .ctrl_addr, .second_score, .aux_out_enable_n, .aux_out_bus, .aux_out_oe,
        .ref_array, .mask_array, .cfg, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    crcl_host_model host (.pclk, .ref_in_bus, .ref_load_strobe, .array_transfer_n, .ctrl_in_bus,
        .ctrl_load_strobe_n, .ctrl_addr, .aux_out_enable_n);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // one strobe: each row head takes an input bit, later stages take the tail
    function automatic logic [7:0][31:0] shift_in(input logic [7:0][31:0] a, input logic [7:0] d,
            input logic [1:0] rl);
        logic [7:0][31:0] o;
        int spr;
        spr = 8 >> rl;
        for (int s = 0; s < 8; s++) begin
            o[s] = {a[s][30:0], (s % spr == 0) ? d[7 - s / spr] : a[(s + 7) % 8][31]};
        end
        return o;
    endfunction

    function automatic logic [8:0] ref_out(input logic [7:0][31:0] a);
        logic [8:0] o;
        o = 9'h000;
        for (int s = 0; s < 8; s++) begin
            o[7 - s] = a[s][31];
        end
        return o;
    endfunction

    task automatic chk(input logic [527:0] got, input logic [527:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s mismatch", $time, what);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never reassigns psel in this step
        @(posedge pclk);
        if (n >= 20) begin
            miscompares++;
            $display("[ERR] %0t apb answer timeout", $time);
            give_verdict();
        end
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        second_score = 9'h000;
        e_pre_ref = '0;
        e_pre_mask = '0;
        e_ref = '0;
        e_mask = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(aux_out_oe, 1'b0, "reset oe");
        chk(ref_array, '0, "reset array");
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            second_score <= r.sc;
            host.ctrl_load(`CRCL_ADDR_CFG, {5'h00, r.cfg});
            e_cfg = r.cfg;
            for (int k = 0; k < r.n; k++) begin
                host.ref_load(r.rd);
                e_pre_ref = shift_in(e_pre_ref, r.rd, r.cfg[1:0]);
            end
            host.ctrl_load(`CRCL_ADDR_MASK, r.md);
            e_pre_mask = shift_in(e_pre_mask, r.md, r.cfg[1:0]);
            nref += r.n;
            nctrl += 2;
            chk(cfg, e_cfg, "config");
            chk(ref_array, e_ref, "array before transfer");
            chk(mask_array, e_mask, "mask before transfer");
            host.xfer();
            e_ref = e_pre_ref;
            e_mask = e_pre_mask;
            chk(ref_array, e_ref, "reference array");
            chk(mask_array, e_mask, "mask array");
            chk(aux_out_bus, r.cfg[2] ? r.sc : ref_out(e_ref), "aux bus");
            $display("row %0d done", i);
        end
        apb(1'b0, `CRCL_OFF_COUNT, 32'h0);
        chk(rd, {nctrl[15:0], nref[15:0]}, "load counts");
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, `CRCL_OFF_TAPSEL, {24'h0, s[2:0], 5'(s * 4 + 3)});
            apb(1'b0, `CRCL_OFF_TAPRD, 32'h0);
            chk(rd[3:0], {e_pre_mask[s][s*4+3], e_pre_ref[s][s*4+3], e_mask[s][s*4+3], e_ref[s][s*4+3]},
                "tap readback");
        end
        $display("apb readback done");
        apb(1'b1, `CRCL_OFF_STATUS, 32'hFFFFFFFF);
        apb(1'b0, `CRCL_OFF_STATUS, 32'h0);
        chk({err, rd}, {1'b0, 28'h0, 1'b1, e_cfg}, "status read only");
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
        for (int a = 2; a < 8; a++) begin
            host.ctrl_load(a[2:0], 8'hFF);
        end
        host.xfer();
        chk(cfg, e_cfg, "ignored codes config");
        chk(mask_array, e_mask, "ignored codes mask");
        $display("ignored codes done");
        host.set_oe(1'b0);
        chk(aux_out_oe, 1'b1, "oe on");
        host.set_oe(1'b1);
        chk({aux_out_oe, ref_array}, {1'b0, e_ref}, "oe off");
        $display("output enable done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({aux_out_bus, aux_out_oe, cfg, ref_array, mask_array}, '0, "mid run reset");
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `CRCL_OFF_COUNT, 32'h0);
        chk(rd, 32'h0, "counts after reset");
        $display("reset done");
        give_verdict();
    end
endmodule
